/* design/ifrsv_crc8.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ifrsv_defines.svh"

module ifrsv_crc8 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  output logic [7:0] crc_o
);

  logic [7:0] crc_ff;
  logic [7:0] nxt_crc;

  always_comb begin
    nxt_crc = crc_ff;
    for (int i = 7; i >= 0; i--) begin
      if (nxt_crc[7] ^ data_i[i]) begin
        nxt_crc = {nxt_crc[6:0], 1'b0} ^ `IFRSV_CRC_POLY;
      end else begin
        nxt_crc = {nxt_crc[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_ff <= `IFRSV_CRC_INIT;
    end else if (clr_i) begin
      crc_ff <= `IFRSV_CRC_INIT;
    end else if (en_i) begin
      crc_ff <= nxt_crc;
    end
  end

  // Byte sent on the wire is the ones complement
  assign crc_o = ~crc_ff;

endmodule : ifrsv_crc8
`default_nettype wire

/* design/ifrsv_defines.svh */
`ifndef IFRSV_DEFINES_SVH
`define IFRSV_DEFINES_SVH

// Register offsets
`define IFRSV_OFS_CTRL2 8'h3d
`define IFRSV_OFS_SVEC 8'h3e
`define IFRSV_OFS_DATA 8'h3f

// Control two bit positions
`define IFRSV_B_NOCRC 0
`define IFRSV_B_CRC 1
`define IFRSV_B_SINGLE 2
`define IFRSV_B_NBFS 3
`define IFRSV_B_EOD 4

// Reset values
`define IFRSV_RST_CTRL2 8'h00
`define IFRSV_RST_SVEC 8'h00
`define IFRSV_RST_DATA 8'h00

// Source codes of the state vector
`define IFRSV_SRC_NONE 4'h0
`define IFRSV_SRC_EOF 4'h1
`define IFRSV_SRC_RX_RESPONSE_BYTE 4'h2
`define IFRSV_SRC_RX_HOLDING_FULL 4'h3
`define IFRSV_SRC_TX_HOLDING_EMPTY 4'h4
`define IFRSV_SRC_ARB 4'h5
`define IFRSV_SRC_CRC 4'h6
`define IFRSV_SRC_INV 4'h7
`define IFRSV_SRC_WAKE 4'h8

// Check sequence
`define IFRSV_CRC_POLY 8'h1d
`define IFRSV_CRC_INIT 8'hff

`endif

/* design/ifrsv_pkg.sv */
package ifrsv_pkg;

  typedef enum logic [2:0] {
    SYM_NONE,
    SYM_NB0,
    SYM_NB1,
    SYM_BYTE,
    SYM_ONES,
    SYM_EOD
  } ifrsv_kind_t;

  typedef struct packed {
    logic valid;
    ifrsv_kind_t kind;
    logic [7:0] data;
  } ifrsv_sym_t;

  typedef struct packed {
    logic eod_ok;
    logic eof;
    logic byte_ok;
    logic byte_ifr;
    logic [7:0] byte_data;
    logic crc_err;
    logic invalid;
    logic wakeup;
    logic arb_lost;
    logic arb_late;
    logic bus_err;
  } ifrsv_rx_t;

endpackage : ifrsv_pkg

/* design/ifrsv_top.sv */
// How it works
// - Crc multi-byte request sends the data register byte as first response byte.
// - Request set before good EOD: after EOD send normalization bit, then bytes.
// - Crc mode: host raises end-of-data after last byte; send byte, crc, EOD.
// - Crc request clears itself on EOD sent, bus error or underrun.
// - Moving a byte into the shifter raises holding-empty, except in single mode; host loads next.
// - Single byte: EOD right after the one byte, no crc, no holding-empty raised.
// - Request written after EOD received stays cleared, nothing sent.
// - Arbitration lost in crc response: flag it, stop, clear request, no retry.
// - Arbitration lost in last two bits still sends two extra ones.
// - No-crc mode ends with last byte and EOD, never a crc byte.
// - No-crc request clears itself on EOD sent, bus error or underrun.
// - Arbitration lost in no-crc response clears request, no resend.
// - State vector is read-only, resets to zero, code in bits 5 to 2.
// - Highest pending source reported as code times four, wakeup highest.
// - Reading the vector clears the reported source except data service ones.
// - Receive sources clear only on vector read then data register read.
// - Holding-empty clears on vector read then data write, or end-of-data set.
// - After a source clears, the next lower pending one shows at once.
// - Several request bits: single over crc over no-crc; readback as written.
`timescale 1ns/1ps
`default_nettype none
`include "ifrsv_defines.svh"

module ifrsv_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RD_DATA_O,
  input wire ifrsv_pkg::ifrsv_rx_t LNK_RX_I,
  input wire logic LNK_SYM_DONE_I,
  output ifrsv_pkg::ifrsv_sym_t LNK_SYM_O,
  output logic TX_BUSY_O
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_NB,
    ST_BYTE,
    ST_CRC,
    ST_EOD,
    ST_ONES
  } ifrsv_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [2:0] req_ff;
  logic nbfs_ff;
  logic eod_req_ff;
  logic eod_seen_ff;
  logic [7:0] hold_ff;
  logic hold_full_ff;
  logic [7:0] rx_data_ff;
  logic [8:1] flag_ff;
  logic [3:0] sv_src_ff;
  logic sv_armed_ff;
  logic [7:0] rd_data_ff;
  logic busy_ff;
  ifrsv_state_t state_ff;
  ifrsv_state_t nxt_state;
  ifrsv_pkg::ifrsv_sym_t sym_ff;
  ifrsv_pkg::ifrsv_sym_t nxt_sym;

  wire sel_ctrl = (ADDR_I == `IFRSV_OFS_CTRL2);
  wire sel_svec = (ADDR_I == `IFRSV_OFS_SVEC);
  wire sel_data = (ADDR_I == `IFRSV_OFS_DATA);
  wire wr_ctrl = WR_I && sel_ctrl;
  wire wr_data = WR_I && sel_data;
  wire rd_svec = RD_I && sel_svec;
  wire rd_data = RD_I && sel_data;
  wire end_of_data_req_set = wr_ctrl && WR_DATA_I[`IFRSV_B_EOD];

  // Priority encoding of the written request bits
  wire act_single = req_ff[`IFRSV_B_SINGLE];
  wire act_crc = !act_single && req_ff[`IFRSV_B_CRC];
  wire act_nocrc = !act_single && !act_crc && req_ff[`IFRSV_B_NOCRC];
  wire act_any = act_single || act_crc || act_nocrc;

  // Normalization bit: one for crc responses, zero otherwise, unless format flipped
  wire nb_one = act_crc ? !nbfs_ff : nbfs_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Response sequencer

  logic load;
  logic finish;
  logic abort;
  logic arb_evt;
  logic crc_clr;
  logic [7:0] crc_val;
  wire done = LNK_SYM_DONE_I;
  wire busy = (state_ff != ST_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_sym = sym_ff;
    load = 1'b0;
    finish = 1'b0;
    abort = 1'b0;
    arb_evt = 1'b0;
    crc_clr = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_sym = '0;
        if (LNK_RX_I.eod_ok && act_any) begin
          nxt_state = ST_NB;
          nxt_sym.valid = 1'b1;
          nxt_sym.kind = nb_one ? ifrsv_pkg::SYM_NB1 : ifrsv_pkg::SYM_NB0;
          crc_clr = 1'b1;
        end
      end
      ST_NB: begin
        if (done) begin
          nxt_state = ST_BYTE;
          nxt_sym.kind = ifrsv_pkg::SYM_BYTE;
          nxt_sym.data = hold_ff;
          load = 1'b1;
        end
      end
      ST_BYTE: begin
        if (done) begin
          if (eod_req_ff || act_single) begin
            if (act_crc) begin
              nxt_state = ST_CRC;
              nxt_sym.kind = ifrsv_pkg::SYM_BYTE;
              nxt_sym.data = crc_val;
            end else begin
              nxt_state = ST_EOD;
              nxt_sym.kind = ifrsv_pkg::SYM_EOD;
            end
          end else if (hold_full_ff) begin
            nxt_sym.data = hold_ff;
            load = 1'b1;
          end else begin
            // Underrun: two extra ones force a byte-boundary fault
            nxt_state = ST_ONES;
            nxt_sym.kind = ifrsv_pkg::SYM_ONES;
            abort = 1'b1;
          end
        end
      end
      ST_CRC: begin
        if (done) begin
          nxt_state = ST_EOD;
          nxt_sym.kind = ifrsv_pkg::SYM_EOD;
        end
      end
      ST_EOD: begin
        if (done) begin
          nxt_state = ST_IDLE;
          nxt_sym = '0;
          finish = 1'b1;
        end
      end
      ST_ONES: begin
        if (done) begin
          nxt_state = ST_IDLE;
          nxt_sym = '0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_sym = '0;
      end
    endcase
    if (busy && state_ff != ST_ONES) begin
      if (LNK_RX_I.bus_err) begin
        nxt_state = ST_IDLE;
        nxt_sym = '0;
        load = 1'b0;
        abort = 1'b1;
      end else if (LNK_RX_I.arb_lost) begin
        arb_evt = 1'b1;
        abort = 1'b1;
        load = 1'b0;
        if (LNK_RX_I.arb_late) begin
          nxt_state = ST_ONES;
          nxt_sym.valid = 1'b1;
          nxt_sym.kind = ifrsv_pkg::SYM_ONES;
        end else begin
          nxt_state = ST_IDLE;
          nxt_sym = '0;
        end
      end
    end
  end

  ifrsv_crc8 u_crc (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .clr_i(crc_clr),
    .en_i(load),
    .data_i(hold_ff),
    .crc_o(crc_val)
  );

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff <= ST_IDLE;
      sym_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sym_ff <= nxt_sym;
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control two, holding register, receive data

  // After end of data only requests armed before it may stay set, e.g. beside end-of-data
  wire [2:0] wr_req = WR_DATA_I[2:0] & (req_ff | {3{!eod_seen_ff}});
  wire [2:0] nxt_req = wr_ctrl ? wr_req : ((finish || abort) ? 3'h0 : req_ff);
  wire nxt_eod_req = end_of_data_req_set || (eod_req_ff && !(finish || abort));

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      req_ff <= 3'h0;
      nbfs_ff <= 1'b0;
      eod_req_ff <= 1'b0;
      eod_seen_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      nbfs_ff <= wr_ctrl ? WR_DATA_I[`IFRSV_B_NBFS] : nbfs_ff;
      eod_req_ff <= nxt_eod_req;
      eod_seen_ff <= LNK_RX_I.eod_ok || (eod_seen_ff && !LNK_RX_I.eof);
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hold_ff <= `IFRSV_RST_DATA;
      hold_full_ff <= 1'b0;
      rx_data_ff <= `IFRSV_RST_DATA;
    end else begin
      hold_ff <= wr_data ? WR_DATA_I : hold_ff;
      hold_full_ff <= wr_data || (hold_full_ff && !load);
      rx_data_ff <= LNK_RX_I.byte_ok ? LNK_RX_I.byte_data : rx_data_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State vector

  logic [3:0] src_code;
  always_comb begin
    src_code = `IFRSV_SRC_NONE;
    for (int i = 1; i <= 8; i++) begin
      if (flag_ff[i]) begin
        src_code = 4'(i);
      end
    end
  end

  wire src_is_rx = (sv_src_ff == `IFRSV_SRC_RX_RESPONSE_BYTE) || (sv_src_ff == `IFRSV_SRC_RX_HOLDING_FULL);
  wire code_svc = (src_code == `IFRSV_SRC_RX_RESPONSE_BYTE) || (src_code == `IFRSV_SRC_RX_HOLDING_FULL) ||
                  (src_code == `IFRSV_SRC_TX_HOLDING_EMPTY);

  logic [8:1] set_v;
  logic [8:1] clr_v;
  always_comb begin
    set_v = '0;
    set_v[`IFRSV_SRC_EOF] = LNK_RX_I.eof;
    set_v[`IFRSV_SRC_RX_RESPONSE_BYTE] = LNK_RX_I.byte_ok && LNK_RX_I.byte_ifr;
    set_v[`IFRSV_SRC_RX_HOLDING_FULL] = LNK_RX_I.byte_ok && !LNK_RX_I.byte_ifr;
    set_v[`IFRSV_SRC_TX_HOLDING_EMPTY] = load && !act_single;
    set_v[`IFRSV_SRC_ARB] = arb_evt;
    set_v[`IFRSV_SRC_CRC] = LNK_RX_I.crc_err;
    set_v[`IFRSV_SRC_INV] = LNK_RX_I.invalid;
    set_v[`IFRSV_SRC_WAKE] = LNK_RX_I.wakeup;
    clr_v = '0;
    if (rd_svec && !code_svc && src_code != `IFRSV_SRC_NONE) begin
      clr_v[src_code] = 1'b1;
    end
    if (rd_data && sv_armed_ff && src_is_rx) begin
      clr_v[sv_src_ff] = 1'b1;
    end
    if ((wr_data && sv_armed_ff && sv_src_ff == `IFRSV_SRC_TX_HOLDING_EMPTY) || end_of_data_req_set) begin
      clr_v[`IFRSV_SRC_TX_HOLDING_EMPTY] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      flag_ff <= '0;
      sv_src_ff <= `IFRSV_SRC_NONE;
      sv_armed_ff <= 1'b0;
    end else begin
      flag_ff <= (flag_ff & ~clr_v) | set_v;
      sv_src_ff <= rd_svec ? src_code : sv_src_ff;
      sv_armed_ff <= rd_svec ? code_svc : (sv_armed_ff && !(rd_data || wr_data));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  wire [7:0] ctrl_rd = {3'h0, eod_req_ff, nbfs_ff, req_ff};
  wire [7:0] svec_rd = {2'h0, src_code, 2'h0};
  wire [7:0] rd_mux = sel_ctrl ? ctrl_rd : sel_svec ? svec_rd : sel_data ? rx_data_ff : 8'h00;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= RD_I ? rd_mux : 8'h00;
    end
  end

  assign RD_DATA_O = rd_data_ff;
  assign LNK_SYM_O = sym_ff;
  assign TX_BUSY_O = busy_ff;

endmodule : ifrsv_top
`default_nettype wire

/* sim/ifrsv_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module ifrsv_chk (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [7:0] RD_DATA_O,
  input wire ifrsv_pkg::ifrsv_rx_t LNK_RX_I,
  input wire logic LNK_SYM_DONE_I,
  input wire ifrsv_pkg::ifrsv_sym_t LNK_SYM_O,
  input wire logic TX_BUSY_O
);
  logic abort;
  assign abort = LNK_RX_I.arb_lost | LNK_RX_I.bus_err;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  //////////////////////////////////////////////////////////////////////////////////////////////////
  a_vec_reserved: assert property (
    RD_I && ADDR_I == 8'h3e |=> RD_DATA_O[7:6] == 2'h0 && RD_DATA_O[1:0] == 2'h0)
    else $error("vector reserved bits set");
  a_read_quiet: assert property (
    !RD_I |=> RD_DATA_O == 8'h00) else $error("read data outside read slot");
  a_busy_cause: assert property (
    $rose(TX_BUSY_O) |-> $past(LNK_RX_I.eod_ok)) else $error("response without end of data");
  a_nb_first: assert property (
    $rose(TX_BUSY_O) |-> LNK_SYM_O.valid
      && LNK_SYM_O.kind inside {ifrsv_pkg::SYM_NB0, ifrsv_pkg::SYM_NB1})
    else $error("response not opened by normalization bit");
  a_sym_hold: assert property (
    LNK_SYM_O.valid && !LNK_SYM_DONE_I && !abort |=> $stable(LNK_SYM_O))
    else $error("symbol changed before done");
  a_arb_stop: assert property (
    LNK_RX_I.arb_lost && !LNK_RX_I.arb_late && TX_BUSY_O |-> ##[1:2] !TX_BUSY_O)
    else $error("no stop after arbitration loss");
  a_late_ones: assert property (
    LNK_RX_I.arb_lost && LNK_RX_I.arb_late && TX_BUSY_O
      |-> ##[1:2] LNK_SYM_O.valid && LNK_SYM_O.kind == ifrsv_pkg::SYM_ONES)
    else $error("no extra ones after late loss");
  a_err_stop: assert property (
    LNK_RX_I.bus_err && TX_BUSY_O |-> ##[1:2] !TX_BUSY_O) else $error("no stop on bus error");
  a_eod_last: assert property (
    LNK_SYM_O.valid && LNK_SYM_O.kind == ifrsv_pkg::SYM_EOD && LNK_SYM_DONE_I
      |-> ##[1:2] !TX_BUSY_O) else $error("busy after end of data sent");
endmodule : ifrsv_chk

`default_nettype wire

/* sim/ifrsv_link_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ifrsv_link_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ifrsv_pkg::ifrsv_sym_t sym_i,
  input wire logic [5:0] dly_i,
  output logic done_o
);
  logic [5:0] cnt_ff;
  // Symbol time on the wire; the count restarts after done so one symbol never finishes twice
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 6'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= sym_i.valid && !done_o && cnt_ff >= dly_i;
      cnt_ff <= (!sym_i.valid || done_o) ? 6'h00 : cnt_ff + 6'h01;
    end
  end
endmodule : ifrsv_link_model

`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ifrsv_defines.svh"

module tb;
  logic clk, rst, wr, rd, done, busy;
  logic [7:0] addr, wdat, rdat, rv, d;
  logic [5:0] dly;
  logic [31:0] lfsr;
  logic [10:0] q[$];
  ifrsv_pkg::ifrsv_rx_t rx;
  ifrsv_pkg::ifrsv_sym_t sym;
  ifrsv_pkg::ifrsv_rx_t ev;
  logic [7:0] vec_ord[5] = '{8'h20, 8'h1c, 8'h18, 8'h0c, 8'h0c};
  int fails, checks_done;

  ifrsv_top dut (.CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdat), .WR_I(wr),
    .RD_I(rd), .RD_DATA_O(rdat), .LNK_RX_I(rx), .LNK_SYM_DONE_I(done), .LNK_SYM_O(sym),
    .TX_BUSY_O(busy));
  ifrsv_link_model far (.clk_i(clk), .rst_i(rst), .sym_i(sym), .dly_i(dly), .done_o(done));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Finished symbols; only byte symbols carry meaningful data
  always @(posedge clk) if (done && sym.valid)
    q.push_back({sym.kind, sym.kind == ifrsv_pkg::SYM_BYTE ? sym.data : 8'h00});
  //////////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  function automatic logic [7:0] crc8(input logic [7:0] b[$]);
    logic [7:0] c = `IFRSV_CRC_INIT;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i][k]) ? `IFRSV_CRC_POLY : 8'h00);
    return ~c;
  endfunction : crc8
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdat <= dat;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    rv = rdat;
  endtask : bus
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk(nm, rv, x);
  endtask : rdc
  task automatic pulse(input ifrsv_pkg::ifrsv_rx_t p);
    @(posedge clk);
    rx <= p;
    @(posedge clk);
    rx <= '0;
  endtask : pulse
  task automatic idle();
    int t = 0;
    #1;
    while (busy !== 1'b0 && t < 3000) begin
      @(posedge clk);
      #1;
      t++;
    end
    chk("idle", busy, 1'b0);
  endtask : idle
  // Close the previous frame so requests are accepted, then arm and see end of data
  task automatic start(input logic [7:0] ctl, input logic [7:0] b0);
    pulse('{eof: 1'b1, default: '0});
    bus(1'b0, `IFRSV_OFS_SVEC, 8'h00);
    q = {};
    bus(1'b1, `IFRSV_OFS_DATA, b0);
    bus(1'b1, `IFRSV_OFS_CTRL2, ctl);
    rdc("ctl2 readback", `IFRSV_OFS_CTRL2, ctl);
    pulse('{eod_ok: 1'b1, default: '0});
  endtask : start
  task automatic resp(input logic [7:0] ctl, input int n, input logic crc);
    logic [7:0] b[$];
    logic [10:0] e[$];
    int t;
    b.push_back(rnd());
    start(ctl, b[0]);
    for (int i = 1; i <= n; i++) begin
      t = 0;
      rv = 8'h00;
      while (rv !== 8'h10 && t < 300) begin
        bus(1'b0, `IFRSV_OFS_SVEC, 8'h00);
        t++;
      end
      chk("holding empty", rv, 8'h10);
      if (i < n) begin
        b.push_back(rnd());
        bus(1'b1, `IFRSV_OFS_DATA, b[i]);
      end else
        bus(1'b1, `IFRSV_OFS_CTRL2, ctl | 8'h10);
    end
    idle();
    e.push_back({(crc ^ ctl[3]) ? ifrsv_pkg::SYM_NB1 : ifrsv_pkg::SYM_NB0, 8'h00});
    foreach (b[i]) e.push_back({ifrsv_pkg::SYM_BYTE, b[i]});
    if (crc) e.push_back({ifrsv_pkg::SYM_BYTE, crc8(b)});
    e.push_back({ifrsv_pkg::SYM_EOD, 8'h00});
    chk("symbol count", 16'(q.size()), 16'(e.size()));
    foreach (e[i]) chk("symbol", q[i], e[i]);
    bus(1'b0, `IFRSV_OFS_CTRL2, 8'h00);
    chk("requests left", rv & 8'h07, 8'h00);
    rdc("vector after end", `IFRSV_OFS_SVEC, 8'h00);
  endtask : resp
  task automatic test_done();
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    fails++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    {wr, rd, addr, wdat, rx} = '0;
    dly = 6'h1e;
    lfsr = 32'h20;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc("ctl2 reset", `IFRSV_OFS_CTRL2, 8'h00);
    rdc("vector reset", `IFRSV_OFS_SVEC, 8'h00);
    rdc("unmapped", 8'h40, 8'h00);
    d = rnd();
    pulse('{eof: 1, wakeup: 1, crc_err: 1, invalid: 1, byte_ok: 1, byte_data: d, default: '0});
    bus(1'b1, `IFRSV_OFS_SVEC, 8'hff);
    foreach (vec_ord[i])
      rdc("vector order", `IFRSV_OFS_SVEC, vec_ord[i]);
    rdc("rx byte", `IFRSV_OFS_DATA, d);
    rdc("vector lower", `IFRSV_OFS_SVEC, 8'h04);
    pulse('{byte_ok: 1, byte_ifr: 1, byte_data: d, default: '0});
    rdc("vector ifr byte", `IFRSV_OFS_SVEC, 8'h08);
    rdc("ifr byte", `IFRSV_OFS_DATA, d);
    rdc("vector cleared", `IFRSV_OFS_SVEC, 8'h00);
    resp(8'h02, 3, 1'b1);
    resp(8'h0b, 1, 1'b1);
    resp((rnd() & 8'h08) | 8'h01, 2, 1'b0);
    resp(8'h07, 0, 1'b0);
    // Nothing armed before end of data: a request written after it must not take
    start(8'h00, rnd());
    bus(1'b1, `IFRSV_OFS_CTRL2, 8'h03);
    bus(1'b0, `IFRSV_OFS_CTRL2, 8'h00);
    chk("late request", rv & 8'h07, 8'h00);
    idle();
    chk("late nothing sent", 16'(q.size()), 16'h0000);
    // Loss, late loss, bus error and underrun in turn
    for (int k = 0; k < 4; k++) begin
      start(k ? 8'h01 : 8'h02, rnd());
      for (int t = 0; t < 200 && sym.kind !== ifrsv_pkg::SYM_BYTE; t++) @(posedge clk);
      chk("byte started", sym.kind, ifrsv_pkg::SYM_BYTE);
      ev = '0;
      ev.arb_lost = (k < 2);
      ev.arb_late = (k == 1);
      ev.bus_err = (k == 2);
      pulse(ev);
      idle();
      bus(1'b0, `IFRSV_OFS_CTRL2, 8'h00);
      chk("request after abort", rv & 8'h07, 8'h00);
      if (k[0])
        chk("abort tail", q[$], {ifrsv_pkg::SYM_ONES, 8'h00});
      else
        chk("abort count", 16'(q.size()), 16'h0001);
      rdc("vector after abort", `IFRSV_OFS_SVEC, k < 2 ? 8'h14 : 8'h10);
      bus(1'b0, `IFRSV_OFS_SVEC, 8'h00);
      if (rv === 8'h10) bus(1'b1, `IFRSV_OFS_DATA, 8'h00);
    end
    test_done();
  end
endmodule : tb

bind ifrsv_top ifrsv_chk chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .RD_DATA_O(RD_DATA_O), .LNK_RX_I(LNK_RX_I), .LNK_SYM_DONE_I(LNK_SYM_DONE_I),
  .LNK_SYM_O(LNK_SYM_O), .TX_BUSY_O(TX_BUSY_O));

`default_nettype wire
